// ===== svr_host.sv
// host processor model: serial clock and open-drain data drive for one-byte commands
`timescale 1ns/1ns
module svr_host (
  // bench clock, link timing is counted in its falling edges
  clk,
  // serial pins
  scl,
  sda_low,
  // resolved data line, pulled up when nobody drives it
  sda
);
  input  wire logic clk;
  output logic      scl;
  output logic      sda_low;
  input  wire logic sda;

  // clock stands high and data is released between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half

  task automatic pins(input logic c, input logic d);
    @(negedge clk);
    scl = c;
    sda_low = !d;
  endtask : pins

  // data moves mid-low; the late sample in the high phase lets a slow ack settle
  task automatic slot(input logic b, output logic seen);
    repeat (2) @(negedge clk);
    sda_low = !b;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (3) @(negedge clk);
    seen = sda;
    @(negedge clk);
    scl = 1'b0;
  endtask : slot

  task automatic send(input logic [7:0] adr, input logic [7:0] dat,
                      output logic ack_a, output logic ack_d);
    logic s;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      slot(adr[i], s);
    end
    slot(1'b1, s);
    ack_a = !s;
    ack_d = 1'b0;
    // a refused address ends the frame at once
    if (ack_a) begin
      for (int i = 7; i >= 0; i--) begin
        slot(dat[i], s);
      end
      slot(1'b1, s);
      ack_d = !s;
    end
    repeat (2) @(negedge clk);
    sda_low = 1'b1;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : send
endmodule : svr_host

// ===== svr_pkg.sv
// constants and carrier types for the serial voltage-id receiver and soft-start control
package svr_pkg;

  localparam int SS_W = 23;

  // soft-start levels in microvolts
  localparam logic [SS_W-1:0] SS_TRACK_UV  = 23'd1400000;
  localparam logic [SS_W-1:0] SS_FLOOR_UV  = 23'd200000;
  localparam logic [SS_W-1:0] SS_DELAY_UV  = 23'd3900000;
  localparam logic [SS_W-1:0] SS_OFFSET_UV = 23'd120000;
  localparam logic [SS_W-1:0] SS_MAX_UV    = 23'd4500000;

  // sink and source currents in 0.1uA, used as microvolts moved per phase tick
  localparam logic [SS_W-1:0] SS_CHARGE_STEP = 23'd470;
  localparam logic [SS_W-1:0] SS_OC_STEP     = 23'd470;
  localparam logic [SS_W-1:0] SS_OFF_STEP    = 23'd500;
  localparam logic [SS_W-1:0] SS_SLOW_STEP   = 23'd45;

  // address byte fields, write bit included, and the off-code prefix of the data byte
  localparam logic [2:0] ADR_PREFIX = 3'b110;
  localparam logic [2:0] ADR_OUT1   = 3'b100;
  localparam logic [2:0] ADR_OUT2   = 3'b010;
  localparam logic [2:0] ADR_BOTH   = 3'b110;
  localparam logic [4:0] OFF_PREFIX = 5'b11111;

  // boot codes as the equivalent seven-bit voltage codes
  localparam logic [6:0] BOOT_VID_1V1 = 7'h24;
  localparam logic [6:0] BOOT_VID_1V0 = 7'h2c;
  localparam logic [6:0] BOOT_VID_0V9 = 7'h34;
  localparam logic [6:0] BOOT_VID_0V8 = 7'h3c;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_ADDR = 5'b00010,
    RX_AACK = 5'b00100,
    RX_DATA = 5'b01000,
    RX_DACK = 5'b10000
  } svr_rx_t;

  typedef struct packed {
    logic [6:0] vid;
    logic       power_state_low_flag;
    logic       off;
  } svr_cmd_t;

  typedef struct packed {
    logic [SS_W-1:0] ss_uv;
    logic [SS_W-1:0] ea_ref_uv;
    logic            ea_low;
    logic            pg;
    logic            fault;
  } svr_ss_t;

  function automatic logic [6:0] boot_vid(input logic [1:0] code);
    case (code)
      2'b00:   boot_vid = BOOT_VID_1V1;
      2'b01:   boot_vid = BOOT_VID_1V0;
      2'b10:   boot_vid = BOOT_VID_0V9;
      default: boot_vid = BOOT_VID_0V8;
    endcase
  endfunction : boot_vid

endpackage : svr_pkg

// ===== svr_softstart.sv
// soft-start capacitor model, fault latch, error-amp clamp and good flag for one output
`timescale 1ns/1ns
module svr_softstart (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             tick,
  // fault and command sources
  input  wire logic             reset_fault,
  input  wire logic             hard_fault,
  input  wire logic             off_cmd,
  input  wire logic             hold_low,
  input  wire logic             overcurrent,
  // status
  output svr_pkg::svr_ss_t      st
);

  logic [svr_pkg::SS_W-1:0] ss_uv_ff;
  logic [svr_pkg::SS_W-1:0] nxt_ss_uv;
  logic                     fault_ff;
  logic                     pg_ff;

  wire above_delay = ss_uv_ff > svr_pkg::SS_DELAY_UV;
  wire below_trip  = ss_uv_ff < (svr_pkg::SS_DELAY_UV - svr_pkg::SS_OFFSET_UV);
  wire at_floor    = ss_uv_ff <= svr_pkg::SS_FLOOR_UV;
  wire oc_after_pg = overcurrent & pg_ff;
  wire oc_in_start = overcurrent & ~pg_ff & ~fault_ff
                     & (ss_uv_ff >= svr_pkg::SS_TRACK_UV);
  wire set_fault   = reset_fault | (oc_after_pg & below_trip) | oc_in_start;
  wire clr_fault   = fault_ff & at_floor & ~reset_fault;
  wire charge_ok   = ~fault_ff & ~hard_fault & ~off_cmd & ~hold_low;

  always_comb begin
    nxt_ss_uv = ss_uv_ff;
    if (fault_ff) begin
      // slow bleed so the next attempt waits out the hiccup period
      if (!at_floor) nxt_ss_uv = ss_uv_ff - svr_pkg::SS_SLOW_STEP;
    end else if (hard_fault || off_cmd) begin
      if (ss_uv_ff > svr_pkg::SS_OFF_STEP) nxt_ss_uv = ss_uv_ff - svr_pkg::SS_OFF_STEP;
      else nxt_ss_uv = '0;
    end else if (oc_after_pg) begin
      nxt_ss_uv = ss_uv_ff - svr_pkg::SS_OC_STEP;
    end else if (charge_ok && ss_uv_ff < svr_pkg::SS_MAX_UV) begin
      nxt_ss_uv = ss_uv_ff + svr_pkg::SS_CHARGE_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ss_uv_ff <= '0;
      fault_ff <= 1'b0;
      pg_ff    <= 1'b0;
    end else if (ce) begin
      if (tick) ss_uv_ff <= nxt_ss_uv;
      // set wins over the floor release
      if (set_fault) fault_ff <= 1'b1;
      else if (clr_fault) fault_ff <= 1'b0;
      if (set_fault || fault_ff || hard_fault) pg_ff <= 1'b0;
      else if (above_delay) pg_ff <= 1'b1;
    end
  end

  // off codes deliberately leave the good flag alone
  assign st.ss_uv     = ss_uv_ff;
  assign st.ea_low    = fault_ff | hard_fault | off_cmd | hold_low
                        | (ss_uv_ff < svr_pkg::SS_TRACK_UV);
  assign st.ea_ref_uv = st.ea_low ? '0 : ss_uv_ff - svr_pkg::SS_TRACK_UV;
  assign st.pg        = pg_ff;
  assign st.fault     = fault_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_ea_clamp_low: assert property (ss_uv_ff < svr_pkg::SS_TRACK_UV |-> st.ea_low)
    else $error("error amp not clamped below track level");
  a_pg_rise_delay: assert property ($rose(pg_ff) |-> $past(ss_uv_ff) > svr_pkg::SS_DELAY_UV)
    else $error("good rose below delay threshold");
  a_fault_drop_pg: assert property (ce && fault_ff |=> !pg_ff)
    else $error("good stayed high under fault");
  a_fault_floor_rel: assert property (ce && clr_fault && !set_fault |=> !fault_ff)
    else $error("fault latch not released at floor");
  a_hold_disables: assert property (hold_low |-> st.ea_low && st.ea_ref_uv == '0)
    else $error("converter not disabled while soft start held low");
  c_hiccup_trip: cover property (oc_after_pg && below_trip ##1 fault_ff);
  c_pg_reached: cover property ($rose(pg_ff));

endmodule : svr_softstart

// ===== svr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module svr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  // async in, synced out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= '0;
      q       <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : svr_sync

// ===== svr_top.sv
// serial voltage-id receiver, boot code capture and fault control for two outputs
`timescale 1ns/1ns
module svr_top (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  // serial voltage-id pins
  input  wire logic                 serial_vid_clock,
  input  wire logic                 serial_vid_data_in,
  output logic                      serial_vid_data_out,
  output logic                      serial_vid_data_oe,
  // system inputs
  input  wire logic                 host_power_ok_input,
  input  wire logic                 enable_in,
  input  wire logic                 gate_drive_low,
  input  wire logic                 gate_drive_good,
  input  wire logic [1:0]           overcurrent_in,
  input  wire logic [1:0]           overvoltage_in,
  input  wire logic [1:0]           remote_sense_open,
  input  wire logic                 phase_chain_open,
  input  wire logic [1:0]           softstart_hold_low,
  // phase-timing strobe from same-clock logic
  input  wire logic                 phase_tick,
  // per-output targets and status
  output svr_pkg::svr_cmd_t [1:0]   vid_cmd,
  output svr_pkg::svr_ss_t  [1:0]   ss_state,
  output logic [1:0]                boot_code,
  output logic                      boot_mode,
  output logic                      regulation_good_output
);

  localparam int NS = 15;

  logic [NS-1:0] pins_s;
  logic          scl_s, sda_s, pok_s, en_s, gdl_s, gdg_s, chain_s;
  logic [1:0]    oc_s, ov_s, so_s, hold_s;

  // the clock pin is only ever sampled, never driven
  svr_sync #(.W(NS)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({serial_vid_clock, serial_vid_data_in, host_power_ok_input, enable_in,
            gate_drive_low, gate_drive_good, overcurrent_in, overvoltage_in,
            remote_sense_open, phase_chain_open, softstart_hold_low}),
    .q    (pins_s)
  );

  assign {scl_s, sda_s, pok_s, en_s, gdl_s, gdg_s, oc_s, ov_s, so_s, chain_s, hold_s} = pins_s;

  // ---------------- receiver ----------------
  svr_pkg::svr_rx_t  rx_ff, nxt_rx;
  logic              scl_d_ff, sda_d_ff, pok_d_ff, en_d_ff;
  logic [6:0]        shift_ff;
  logic [2:0]        cnt_ff;
  logic              ack_ff;
  logic [1:0]        sel_ff;
  svr_pkg::svr_cmd_t [1:0] cmd_ff;
  logic [1:0]        boot_ff;
  logic [1:0]        hard_ff;
  logic              boot_mode_ff;

  wire scl_rise  = scl_s & ~scl_d_ff;
  wire scl_fall  = ~scl_s & scl_d_ff;
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire [7:0] byte_in  = {shift_ff, sda_s};
  wire       last_bit = scl_rise & (cnt_ff == 3'd7);
  wire       svi_on   = pok_s;

  // write bit is byte_in[0] and must be low for every pattern
  wire match_out1 = byte_in[2:0] == svr_pkg::ADR_OUT1;
  wire match_out2 = byte_in[2:0] == svr_pkg::ADR_OUT2;
  wire match_both = byte_in[2:0] == svr_pkg::ADR_BOTH;
  wire adr_match  = (byte_in[7:5] == svr_pkg::ADR_PREFIX)
                    & (match_out1 | match_out2 | match_both);
  wire [1:0] adr_sel = {match_out2 | match_both, match_out1 | match_both};

  wire data_done = (rx_ff == svr_pkg::RX_DATA) & last_bit;
  wire off_code  = byte_in[6:2] == svr_pkg::OFF_PREFIX;

  always_comb begin
    nxt_rx = rx_ff;
    if (!svi_on) begin
      nxt_rx = svr_pkg::RX_IDLE;
    end else if (start_det) begin
      nxt_rx = svr_pkg::RX_ADDR;
    end else if (stop_det) begin
      nxt_rx = svr_pkg::RX_IDLE;
    end else begin
      unique case (rx_ff)
        svr_pkg::RX_IDLE: nxt_rx = svr_pkg::RX_IDLE;
        svr_pkg::RX_ADDR: begin
          if (last_bit) nxt_rx = adr_match ? svr_pkg::RX_AACK : svr_pkg::RX_IDLE;
        end
        svr_pkg::RX_AACK: begin
          if (scl_fall && ack_ff) nxt_rx = svr_pkg::RX_DATA;
        end
        svr_pkg::RX_DATA: begin
          if (last_bit) nxt_rx = svr_pkg::RX_DACK;
        end
        svr_pkg::RX_DACK: begin
          if (scl_fall && ack_ff) nxt_rx = svr_pkg::RX_IDLE;
        end
        default: nxt_rx = svr_pkg::RX_IDLE;
      endcase
    end
  end

  wire in_ack = (rx_ff == svr_pkg::RX_AACK) | (rx_ff == svr_pkg::RX_DACK);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_ff    <= svr_pkg::RX_IDLE;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      shift_ff <= '0;
      cnt_ff   <= '0;
      ack_ff   <= 1'b0;
      sel_ff   <= '0;
    end else if (ce) begin
      rx_ff    <= nxt_rx;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      if (start_det || !in_ack && nxt_rx != rx_ff) cnt_ff <= '0;
      else if (scl_rise && !in_ack) begin
        cnt_ff   <= cnt_ff + 3'd1;
        shift_ff <= byte_in[6:0];
      end
      if (rx_ff == svr_pkg::RX_ADDR && last_bit) sel_ff <= adr_sel;
      // pull data low from the fall after the 8th bit to the next fall
      if (!in_ack || nxt_rx != rx_ff) ack_ff <= 1'b0;
      else if (scl_fall) ack_ff <= 1'b1;
    end
  end

  assign serial_vid_data_out = 1'b0;
  assign serial_vid_data_oe  = ack_ff;

  // ---------------- targets, boot and latches ----------------
  wire en_rise    = en_s & ~en_d_ff;
  wire no_fault   = ~gdl_s & ~(|hard_ff);
  wire boot_load  = en_rise & no_fault;
  wire pok_fall   = ~pok_s & pok_d_ff & en_s;
  wire [1:0] hard_set = ov_s | so_s | {2{chain_s}};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pok_d_ff     <= 1'b0;
      en_d_ff      <= 1'b0;
      boot_ff      <= '0;
      boot_mode_ff <= 1'b1;
      hard_ff      <= '0;
      cmd_ff       <= '0;
    end else if (ce) begin
      pok_d_ff     <= pok_s;
      en_d_ff      <= en_s;
      boot_mode_ff <= ~pok_s;
      for (int i = 0; i < 2; i++) begin
        // set wins; release only while gate_drive_good is low, i.e. the supply is below its good level
        if (hard_set[i]) hard_ff[i] <= 1'b1;
        else if (!gdg_s) hard_ff[i] <= 1'b0;
        if (boot_load) begin
          cmd_ff[i].vid <= svr_pkg::boot_vid({scl_s, sda_s});
          cmd_ff[i].off <= 1'b0;
        end else if (pok_fall) begin
          cmd_ff[i].vid <= svr_pkg::boot_vid(boot_ff);
          cmd_ff[i].off <= 1'b0;
        end else if (data_done && sel_ff[i]) begin
          cmd_ff[i].power_state_low_flag <= byte_in[7];
          if (off_code) cmd_ff[i].off <= 1'b1;
          else begin
            cmd_ff[i].vid <= byte_in[6:0];
            cmd_ff[i].off <= 1'b0;
          end
        end
      end
      if (boot_load) boot_ff <= {scl_s, sda_s};
    end
  end

  // enable low or supply under 86% resets through the resettable latch
  wire reset_src = gdl_s | ~en_s;

  for (genvar g = 0; g < 2; g++) begin : g_ss
    svr_softstart u_ss (
      .clk         (clk),
      .rstn        (rstn),
      .ce          (ce),
      .tick        (phase_tick),
      .reset_fault (reset_src),
      .hard_fault  (hard_ff[g]),
      .off_cmd     (cmd_ff[g].off),
      .hold_low    (hold_s[g]),
      .overcurrent (oc_s[g]),
      .st          (ss_state[g])
    );
  end

  assign vid_cmd                = cmd_ff;
  assign boot_code              = boot_ff;
  assign boot_mode              = boot_mode_ff;
  assign regulation_good_output = ss_state[0].pg & ss_state[1].pg;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_no_ack_mismatch: assert property (ce && svi_on && !start_det && !stop_det
      && rx_ff == svr_pkg::RX_ADDR && last_bit && !adr_match |=> rx_ff == svr_pkg::RX_IDLE)
    else $error("unmatched address did not return to idle");
  a_ack_only_slot: assert property (serial_vid_data_oe |-> in_ack)
    else $error("data line driven outside an acknowledge slot");
  a_ack_one_bit: assert property (ce && $rose(ack_ff) && svi_on |-> ack_ff [*4])
    else $error("acknowledge released early");
  a_ignore_no_pok: assert property (ce && !svi_on |=> rx_ff == svr_pkg::RX_IDLE && !ack_ff)
    else $error("receiver active without power ok");
  a_off_code_hold: assert property (ce && data_done && svi_on && off_code && sel_ff[0]
      && !boot_load && !pok_fall |=> cmd_ff[0].off)
    else $error("off code did not turn output off");
  a_vid_load: assert property (ce && data_done && svi_on && !off_code && sel_ff[1]
      && !boot_load && !pok_fall |=> cmd_ff[1].vid == $past(byte_in[6:0]) && !cmd_ff[1].off)
    else $error("new code not loaded into reference");
  a_boot_capture: assert property (ce && boot_load |=> boot_ff == $past({scl_s, sda_s})
      && cmd_ff[0].vid == svr_pkg::boot_vid(boot_ff))
    else $error("boot code not captured");
  a_pok_fall_boot: assert property (ce && pok_fall && !boot_load
      |=> cmd_ff[0].vid == svr_pkg::boot_vid(boot_ff))
    else $error("power ok drop did not restore boot code");
  a_hard_latch: assert property (ce && hard_ff[0] && gdg_s |=> hard_ff[0])
    else $error("hard fault cleared without supply cycle");
  c_addr_ack: cover property (rx_ff == svr_pkg::RX_AACK && ack_ff);
  c_full_cmd: cover property (rx_ff == svr_pkg::RX_DACK && ack_ff);
  c_off_then_on: cover property (cmd_ff[0].off ##1 !cmd_ff[0].off);

endmodule : svr_top

// ===== svr_top_tb.sv
// self-checking bench: boot capture, serial commands, off codes and fault handling
`timescale 1ns/1ns
module svr_top_tb;
  logic                    clk, rstn, pok, en, gd_good, oe, dout, bmode, good;
  logic                    scl, sda_low, sda, aa, ad;
  logic                    tick = 1'b0;
  logic [1:0]              ov, oc, hold, bc, boot, bcode;
  logic [7:0]              adr, dat;
  logic [6:0]              exp_vid [2];
  logic [2:0]              sel [4] = '{3'b100, 3'b010, 3'b110, 3'b101};
  svr_pkg::svr_cmd_t [1:0] vid;
  svr_pkg::svr_ss_t  [1:0] ss;
  int                      error_cnt, check_count, seed, i;

  // open-drain data line with pull-up
  assign sda = !(sda_low | (oe & !dout));

  svr_host host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

  svr_top uut (
    .clk(clk), .rstn(rstn), .ce(1'b1), .serial_vid_clock(scl), .serial_vid_data_in(sda),
    .serial_vid_data_out(dout), .serial_vid_data_oe(oe), .host_power_ok_input(pok),
    .enable_in(en), .gate_drive_low(1'b0), .gate_drive_good(gd_good),
    .overcurrent_in(oc), .overvoltage_in(ov), .remote_sense_open(2'b00),
    .phase_chain_open(1'b0), .softstart_hold_low(hold), .phase_tick(tick), .vid_cmd(vid),
    .ss_state(ss), .boot_code(bcode), .boot_mode(bmode), .regulation_good_output(good)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk) begin
    tick <= !tick;
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [6:0] boot_exp(input logic [1:0] c);
    case (c)
      2'b00:   boot_exp = svr_pkg::BOOT_VID_1V1;
      2'b01:   boot_exp = svr_pkg::BOOT_VID_1V0;
      2'b10:   boot_exp = svr_pkg::BOOT_VID_0V9;
      default: boot_exp = svr_pkg::BOOT_VID_0V8;
    endcase
  endfunction : boot_exp

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // soft start to good takes about 17k cycles, the whole run well under this
  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    seed = 33914;
    error_cnt = 0;
    check_count = 0;
    {rstn, pok, en, ov, oc, hold} = '0;
    gd_good = 1'b1;
    cyc(20);
    rstn = 1'b1;
    chk("boot_mode", bmode, 1);
    chk("ack drive", oe, 0);
    boot = $random(seed);
    host.pins(boot[1], boot[0]);
    cyc(4);
    en = 1'b1;
    cyc(10);
    host.pins(1'b1, 1'b1);
    exp_vid[0] = boot_exp(boot);
    exp_vid[1] = exp_vid[0];
    chk("boot_code", bcode, boot);
    chk("good early", good, 0);
    for (int k = 0; k < 2; k++) begin
      chk("boot vid", vid[k].vid, exp_vid[k]);
    end
    host.send(8'hc4, 8'h10, aa, ad);
    chk("ack before power ok", aa, 0);
    chk("vid before power ok", vid[0].vid, exp_vid[0]);
    pok = 1'b1;
    cyc(6);
    chk("boot_mode", bmode, 0);
    for (i = 0; i < 8; i++) begin
      bc = $random(seed);
      dat = $random(seed);
      if (dat[6:2] == 5'h1f) begin
        dat[6] = 1'b0;
      end
      adr = (i == 7) ? {3'b010, bc, 3'b100} : {3'b110, bc, sel[i % 4]};
      host.send(adr, dat, aa, ad);
      chk("address ack", aa, i % 4 != 3);
      chk("data ack", ad, i % 4 != 3);
      if (i % 4 != 3) begin
        chk("psi", vid[adr[2] ? 0 : 1].power_state_low_flag, dat[7]);
        exp_vid[0] = adr[2] ? dat[6:0] : exp_vid[0];
        exp_vid[1] = adr[1] ? dat[6:0] : exp_vid[1];
      end
      for (int k = 0; k < 2; k++) begin
        chk("vid", vid[k].vid, exp_vid[k]);
      end
    end
    for (i = 0; i < 40000 && good !== 1'b1; i++) begin
      cyc(1);
    end
    chk("regulation good", good, 1);
    chk("above delay level", ss[0].ss_uv > svr_pkg::SS_DELAY_UV, 1);
    hold = 2'b01;
    cyc(6);
    chk("ea low on hold", ss[0].ea_low, 1);
    hold = 2'b00;
    cyc(6);
    chk("ea free", ss[0].ea_low, 0);
    chk("ea ref", ss[0].ea_ref_uv, ss[0].ss_uv - svr_pkg::SS_TRACK_UV);
    host.send(8'hc4, {6'h1f, bc}, aa, ad);
    chk("off flag", vid[0].off, 1);
    chk("ea low on off", ss[0].ea_low, 1);
    chk("good kept on off", good, 1);
    chk("other output on", vid[1].off, 0);
    host.send(8'hc4, 8'h30, aa, ad);
    chk("off cleared", vid[0].off, 0);
    chk("new vid", vid[0].vid, 7'h30);
    pok = 1'b0;
    cyc(6);
    for (int k = 0; k < 2; k++) begin
      chk("vid back to boot", vid[k].vid, boot_exp(boot));
    end
    ov = 2'b10;
    cyc(6);
    chk("ea low on overvoltage", ss[1].ea_low, 1);
    ov = 2'b00;
    cyc(20);
    chk("good held low", good, 0);
    // output 0 still has good set, so over-current bleeds it down to the trip level
    oc = 2'b01;
    for (i = 0; i < 6000 && ss[0].fault !== 1'b1; i++) begin
      cyc(1);
    end
    chk("fault on over-current", ss[0].fault, 1);
    chk("good dropped on over-current", ss[0].pg, 0);
    chk("ea low on over-current", ss[0].ea_low, 1);
    oc = 2'b00;
    en = 1'b0;
    cyc(6);
    chk("fault on enable low", ss[0].fault, 1);
    gd_good = 1'b0;
    cyc(6);
    gd_good = 1'b1;
    cyc(6);
    tally_and_finish();
  end
endmodule : svr_top_tb
